// >>> sbc_consts.svh
// Purpose: shared constants of the mode and wake-up controller
// Assumes: 20 MHz internal clock, one microsecond timebase tick
// Notes: times stay in their own unit, counts are derived from them
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH

// ************************************************************
// clock and timebase
// ************************************************************
`define SBC_CLK_MHZ 20
`define SBC_TICK_US 1
`define SBC_TICK_CYC (`SBC_TICK_US * `SBC_CLK_MHZ)

// ************************************************************
// times, counted in timebase ticks, the filter also in clock cycles
// ************************************************************
`define SBC_FILT_US 20
`define SBC_FILT_CYC (`SBC_FILT_US * `SBC_CLK_MHZ)
`define SBC_RST_MS 1
`define SBC_RST_US (`SBC_RST_MS * 1000 / `SBC_TICK_US)
`define SBC_NRQ_TO_MS 75
`define SBC_NRQ_TO_US (`SBC_NRQ_TO_MS * 1000 / `SBC_TICK_US)
`define SBC_V1LOW_MS 100
`define SBC_V1LOW_US (`SBC_V1LOW_MS * 1000 / `SBC_TICK_US)
`define SBC_CYC_ON_US (400 / `SBC_TICK_US)
`define SBC_CYC_SMP_US (300 / `SBC_TICK_US)
`define SBC_CYC_BASE_MS 32
`define SBC_CYC_BASE_US (`SBC_CYC_BASE_MS * 1000 / `SBC_TICK_US)
`define SBC_CYC_MAX_SHIFT 4'h8

// ************************************************************
// mode codes and wake sense selections
// ************************************************************
`define SBC_CODE_STBY 3'h1
`define SBC_CODE_NORMAL 3'h2
`define SBC_CODE_SLEEP 3'h4
`define SBC_CODE_EMERG 3'h7
`define SBC_SENSE_OFF 2'h0
`define SBC_SENSE_HIGH 2'h1
`define SBC_SENSE_LOW 2'h2
`define SBC_SENSE_BOTH 2'h3

`endif

// >>> sbc_pkg.sv
// Purpose: types of the mode and wake-up controller
// Assumes: constants live in sbc_consts.svh
// Notes: none
package sbc_pkg;
	typedef enum logic [2:0] {st_reset, st_nrq, st_normal, st_stby, st_sleep, st_emerg} sbc_mode_t;
	typedef logic [1:0] sbc_sense_t;
endpackage

// >>> sbc_timebase.sv
// Purpose: free-running microsecond tick
// Assumes: divider of at least two
// Notes: never stopped, so sleep timing keeps going
`timescale 1ns/1ps
`include "sbc_consts.svh"
module sbc_timebase #(
	parameter int P_DIV = `SBC_TICK_CYC
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// tick
	output logic o_tick
);
	import sbc_pkg::*;
	localparam int W = $clog2(P_DIV);
	logic [W-1:0] pre_ff;
	logic tick_ff;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			pre_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= (pre_ff == W'(P_DIV - 1));
			if (pre_ff == W'(P_DIV - 1)) pre_ff <= '0;
			else pre_ff <= pre_ff + 1'b1;
		end
	end

	assign o_tick = tick_ff;
endmodule

// >>> sbc_wake_filter.sv
// Purpose: one local wake input, permanent filter and cyclic samples
// Assumes: input already synchronised
// Notes: o_wake stays high while a high or low level stays valid, pulses one cycle on both-edge changes and samples
`timescale 1ns/1ps
`include "sbc_consts.svh"
module sbc_wake_filter #(
	parameter int P_FILT_CYC = `SBC_FILT_CYC
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// input and control
	input wire logic i_lvl,
	input wire sbc_pkg::sbc_sense_t i_sel,
	input wire logic i_perm_en,
	input wire logic i_smp,
	input wire logic i_clr,
	// result
	output logic o_wake
);
	import sbc_pkg::*;
	localparam int CW = $clog2(P_FILT_CYC + 1);
	logic [CW-1:0] cnt_ff;
	logic filt_ff;
	logic chg_ff;
	logic [3:0] hist_ff;
	logic [2:0] nsmp_ff;
	logic [3:0] nxt_hist;
	logic pat_hit;
	logic lvl_hit;
	logic wake_ff;

	// ************************************************************
	// permanent sense filter
	// ************************************************************
	// a new level must stand longer than the filter time
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_ff <= '0;
			filt_ff <= 1'b0;
			chg_ff <= 1'b0;
		end else begin
			chg_ff <= 1'b0;
			if (i_lvl == filt_ff) begin
				cnt_ff <= '0;
			end else if (cnt_ff == CW'(P_FILT_CYC)) begin
				filt_ff <= i_lvl;
				chg_ff <= 1'b1;
				cnt_ff <= '0;
			end else begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	// ************************************************************
	// cyclic sample history
	// ************************************************************
	assign nxt_hist = {hist_ff[2:0], i_lvl};

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			hist_ff <= 4'h0;
			nsmp_ff <= 3'h0;
		end else if (i_clr) begin
			hist_ff <= 4'h0;
			nsmp_ff <= 3'h0;
		end else if (i_smp) begin
			hist_ff <= nxt_hist;
			if (nsmp_ff != 3'h4) nsmp_ff <= nsmp_ff + 3'h1;
		end
	end

	always_comb begin
		pat_hit = 1'b0;
		lvl_hit = 1'b0;
		case (i_sel)
			`SBC_SENSE_HIGH: begin
				pat_hit = (nxt_hist == 4'h3);
				lvl_hit = filt_ff;
			end
			`SBC_SENSE_LOW: begin
				pat_hit = (nxt_hist == 4'hc);
				lvl_hit = !filt_ff;
			end
			`SBC_SENSE_BOTH: begin
				pat_hit = (nxt_hist == 4'h3) || (nxt_hist == 4'hc);
				lvl_hit = chg_ff;
			end
			default: begin
				pat_hit = 1'b0;
			end
		endcase
	end

	// history must hold four samples before a pattern counts
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) wake_ff <= 1'b0;
		else wake_ff <= (i_perm_en && lvl_hit) || (i_smp && !i_clr && nsmp_ff >= 3'h3 && pat_hit);
	end

	assign o_wake = wake_ff;
endmodule

// >>> sbc_mode_ctrl.sv
// Purpose: mode sequencer and wake-up logic of a system basis chip
// Assumes: pins are asynchronous, fault sources and reads are on i_mclk
// Notes: spi framing and watchdog windows sit outside, pulses come in
// Behaviour
// - rising edge needs two lows, two highs
// - falling or both edges need mirrored pairs
// - cyclic switched output pulsing only in sleep
// - cyclic period from eight selectable values
// - output on 400 us, sample at 300 us
// - sleep runs cyclic or timed wake, not both
// - permanent sense gated by switched feed
// - live state readable, wake sets flag, interrupt
// - sleep local wake goes to reset, sets flag
// - chip select fall wakes once regulator off
// - interrupt from eight individually masked sources
// - reset pin held low one millisecond
// - external reset pin leads to normal request
// - ground shift sampled at transmit falling edge
// - normal request times out, watchdog fail resets
// - mode changes only on matching paired write
// - any of four wake sources leaves sleep
// - regulator low too long enters sleep, option
// - can and chip select wake always enabled
// - sleep refused while any wake flag pending
// - watchdog runs, interrupt live in normal, standby
// - level wake needs input stable beyond filter
// - cyclic sense wins over timed wake
`timescale 1ns/1ps
`include "sbc_consts.svh"
module sbc_mode_ctrl #(
	parameter int P_TICK_CYC = `SBC_TICK_CYC,
	parameter int P_FILT_CYC = `SBC_FILT_CYC,
	parameter int P_RST_US = `SBC_RST_US,
	parameter int P_NRQ_TO_US = `SBC_NRQ_TO_US,
	parameter int P_V1LOW_US = `SBC_V1LOW_US,
	parameter int P_CYC_ON_US = `SBC_CYC_ON_US,
	parameter int P_CYC_SMP_US = `SBC_CYC_SMP_US,
	parameter int P_CYC_BASE_US = `SBC_CYC_BASE_US,
	parameter bit P_V1LOW_SLEEP = 1'b0,
	parameter int P_NWAKE = 3
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// mode and watchdog writes
	input wire logic i_mcr_wr,
	input wire logic [2:0] i_mcr_code,
	input wire logic i_mode_confirm_reg_wr,
	input wire logic [2:0] i_mode_confirm_reg_code,
	input wire logic i_wdt_wr,
	input wire logic i_wd_fail,
	// configuration
	input wire logic [2:0] i_cyc_sel,
	input wire logic i_cyc_en,
	input wire logic i_fwu_en,
	input wire logic i_wi2v3,
	input wire logic i_v3_on,
	input wire sbc_pkg::sbc_sense_t i_sense_sel,
	input wire logic [1:0] i_gs_sel,
	input wire logic [7:0] i_irq_mask,
	// status reads, each clears its flags
	input wire logic i_rd_wake,
	input wire logic i_rd_interrupt_source_reg_two,
	input wire logic i_rd_gs,
	input wire logic i_rd_wake_input_config_reg,
	input wire logic i_rd_rsr,
	input wire logic i_rd_supply_status_reg,
	// fault sources on this clock
	input wire logic [5:0] i_fault_src,
	// pins
	input wire logic [P_NWAKE-1:0] i_local_wake,
	input wire logic i_cs_n,
	input wire logic i_txd,
	input wire logic [3:0] i_canh_below,
	input wire logic i_can_wake,
	input wire logic i_v1_low,
	input wire logic i_v1_off,
	input wire logic i_rst_n_pin,
	output logic o_rst_n_out,
	output logic o_rst_n_oe,
	output logic o_int_n,
	// supplies and mode
	output sbc_pkg::sbc_mode_t o_mode,
	output logic o_v1_en,
	output logic o_v2_en,
	output logic o_v3_en,
	output logic o_wd_run,
	// status
	output logic [P_NWAKE-1:0] o_live_state,
	output logic [P_NWAKE-1:0] o_wake_status,
	output logic o_spi_wake,
	output logic o_can_wake,
	output logic o_gs_shift,
	output logic o_rst_cause,
	output logic o_battery_loss_flag
);
	import sbc_pkg::*;
	localparam int TW = 24;
	localparam int NP = P_NWAKE + 10;
	logic us_tick;
	logic [NP-1:0] pin_raw;
	logic [NP-1:0] pin_s1_ff;
	logic [NP-1:0] pin_s2_ff;
	logic [P_NWAKE-1:0] lw_s;
	logic [3:0] canh_s;
	logic cs_s, tx_s, can_s, v1_low_s, v1_off_s, rst_pin_s;
	logic cs_prev_ff, tx_prev_ff, cs_fall, tx_fall;
	sbc_mode_t mode_ff, nxt_mode;
	logic [2:0] mcr_ff;
	logic [2:0] slp_sel_ff;
	logic [3:0] shamt;
	logic [TW-1:0] rst_cnt_ff, nrq_cnt_ff, v1low_cnt_ff, per_cnt_ff, on_cnt_ff, per_len;
	logic awake, pair_hit, pend, rst_drive, enter_sleep, per_done, fwu_hit, spi_hit, perm_en, wake_any;
	logic cyc_on_ff, smp_ff, slp_cyc_ff, slp_fwu_ff, slp_v3fed_ff;
	logic v1_en_ff, v2_en_ff, v3_ff, wd_run_ff, int_ff;
	logic spi_wake_ff, can_wake_ff, gs_ff, rcause_ff, batloss_ff;
	logic [P_NWAKE-1:0] lw_wake, wake_st_ff, live_ff;
	logic [7:0] irq_vec;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	// ************************************************************
	// pin synchronisers and edges
	// ************************************************************
	assign pin_raw = {i_rst_n_pin, i_v1_off, i_v1_low, i_can_wake, i_canh_below, i_txd, i_cs_n, i_local_wake};

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
		end else begin
			pin_s1_ff <= pin_raw;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	assign lw_s = pin_s2_ff[P_NWAKE-1:0];
	assign cs_s = pin_s2_ff[P_NWAKE];
	assign tx_s = pin_s2_ff[P_NWAKE+1];
	assign canh_s = pin_s2_ff[P_NWAKE+5:P_NWAKE+2];
	assign can_s = pin_s2_ff[P_NWAKE+6];
	assign v1_low_s = pin_s2_ff[P_NWAKE+7];
	assign v1_off_s = pin_s2_ff[P_NWAKE+8];
	assign rst_pin_s = pin_s2_ff[P_NWAKE+9];

	// previous levels reset low so release of reset gives no false fall
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			cs_prev_ff <= 1'b0;
			tx_prev_ff <= 1'b0;
		end else begin
			cs_prev_ff <= cs_s;
			tx_prev_ff <= tx_s;
		end
	end

	assign cs_fall = cs_prev_ff && !cs_s;
	assign tx_fall = tx_prev_ff && !tx_s;

	sbc_timebase #(.P_DIV(P_TICK_CYC)) u_tb (.i_mclk(i_mclk), .i_rstn(i_rstn), .o_tick(us_tick));

	// ************************************************************
	// mode sequencer
	// ************************************************************
	assign awake = (mode_ff == st_normal) || (mode_ff == st_stby);
	assign pair_hit = i_mode_confirm_reg_wr && (i_mode_confirm_reg_code == mcr_ff);
	assign pend = (|wake_st_ff) || spi_wake_ff || can_wake_ff || rcause_ff || batloss_ff;
	assign rst_drive = ((mode_ff == st_reset) && (rst_cnt_ff != TW'(P_RST_US)))
		|| (mode_ff == st_sleep) || (mode_ff == st_emerg);
	assign spi_hit = (mode_ff == st_sleep) && cs_fall && v1_off_s;
	assign fwu_hit = (mode_ff == st_sleep) && slp_fwu_ff && per_done;
	assign wake_any = can_s || spi_hit || fwu_hit || (|lw_wake);

	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			st_reset: begin
				if (!v1_low_s && !rst_drive && rst_pin_s) nxt_mode = st_nrq;
			end
			st_nrq: begin
				// only the emergency request counts before the timing word
				if (pair_hit && i_mode_confirm_reg_code == `SBC_CODE_EMERG) nxt_mode = st_emerg;
				else if (i_wdt_wr) nxt_mode = st_normal;
				else if (nrq_cnt_ff == TW'(P_NRQ_TO_US)) nxt_mode = st_sleep;
			end
			st_normal, st_stby: begin
				if (pair_hit) begin
					case (i_mode_confirm_reg_code)
						`SBC_CODE_NORMAL: nxt_mode = st_normal;
						`SBC_CODE_STBY: nxt_mode = st_stby;
						`SBC_CODE_SLEEP: nxt_mode = pend ? mode_ff : st_sleep;
						`SBC_CODE_EMERG: nxt_mode = st_emerg;
						default: nxt_mode = mode_ff;
					endcase
				end
				if (i_wd_fail) nxt_mode = st_reset;
			end
			st_sleep: begin
				if (wake_any) nxt_mode = st_reset;
			end
			st_emerg: begin
				nxt_mode = st_emerg;
			end
			default: begin
				nxt_mode = st_reset;
			end
		endcase
		if ((awake || mode_ff == st_nrq) && (v1_low_s || !rst_pin_s)) nxt_mode = st_reset;
		if (P_V1LOW_SLEEP && v1low_cnt_ff == TW'(P_V1LOW_US)) nxt_mode = st_sleep;
	end

	assign enter_sleep = (nxt_mode == st_sleep) && (mode_ff != st_sleep);

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) mode_ff <= st_reset;
		else mode_ff <= nxt_mode;
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) mcr_ff <= 3'h0;
		else if (i_mcr_wr) mcr_ff <= i_mcr_code;
	end

	// an external pulse skips our own drive, only its release is awaited
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_cnt_ff <= '0;
		end else if (mode_ff != st_reset) begin
			if ((awake || mode_ff == st_nrq) && !rst_pin_s && !v1_low_s) rst_cnt_ff <= TW'(P_RST_US);
			else rst_cnt_ff <= '0;
		end else if (v1_low_s) begin
			rst_cnt_ff <= '0;
		end else if (us_tick && rst_cnt_ff != TW'(P_RST_US)) begin
			rst_cnt_ff <= rst_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) nrq_cnt_ff <= '0;
		else if (mode_ff != st_nrq) nrq_cnt_ff <= '0;
		else if (us_tick && nrq_cnt_ff != TW'(P_NRQ_TO_US)) nrq_cnt_ff <= nrq_cnt_ff + 1'b1;
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) v1low_cnt_ff <= '0;
		else if (!v1_low_s || mode_ff == st_sleep || mode_ff == st_emerg) v1low_cnt_ff <= '0;
		else if (us_tick && v1low_cnt_ff != TW'(P_V1LOW_US)) v1low_cnt_ff <= v1low_cnt_ff + 1'b1;
	end

	// ************************************************************
	// sleep options, cyclic sense and timed wake
	// ************************************************************
	// options are frozen on entry, so host changes in sleep are moot
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			slp_cyc_ff <= 1'b0;
			slp_fwu_ff <= 1'b0;
			slp_v3fed_ff <= 1'b0;
			slp_sel_ff <= 3'h0;
		end else if (enter_sleep) begin
			slp_cyc_ff <= i_cyc_en;
			slp_fwu_ff <= i_fwu_en && !i_cyc_en;
			slp_v3fed_ff <= i_wi2v3;
			slp_sel_ff <= i_cyc_sel;
		end
	end

	assign shamt = (slp_sel_ff == 3'h7) ? `SBC_CYC_MAX_SHIFT : {1'b0, slp_sel_ff};
	assign per_len = TW'(P_CYC_BASE_US) << shamt;
	assign per_done = us_tick && (per_cnt_ff == per_len - 1'b1);

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) per_cnt_ff <= '0;
		else if (mode_ff != st_sleep || !(slp_cyc_ff || slp_fwu_ff)) per_cnt_ff <= '0;
		else if (per_done) per_cnt_ff <= '0;
		else if (us_tick) per_cnt_ff <= per_cnt_ff + 1'b1;
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			cyc_on_ff <= 1'b0;
			on_cnt_ff <= '0;
			smp_ff <= 1'b0;
		end else begin
			smp_ff <= 1'b0;
			if (mode_ff != st_sleep) begin
				cyc_on_ff <= 1'b0;
				on_cnt_ff <= '0;
			end else if (slp_cyc_ff && per_done) begin
				cyc_on_ff <= 1'b1;
				on_cnt_ff <= '0;
			end else if (cyc_on_ff && us_tick) begin
				on_cnt_ff <= on_cnt_ff + 1'b1;
				if (on_cnt_ff == TW'(P_CYC_SMP_US - 1)) smp_ff <= 1'b1;
				if (on_cnt_ff == TW'(P_CYC_ON_US - 1)) cyc_on_ff <= 1'b0;
			end
		end
	end

	// ************************************************************
	// local wake inputs
	// ************************************************************
	assign perm_en = awake ? (!i_wi2v3 || v3_ff) : ((mode_ff == st_sleep) && !slp_v3fed_ff);

	for (genvar gi = 0; gi < P_NWAKE; gi++) begin : g_wake
		sbc_wake_filter #(.P_FILT_CYC(P_FILT_CYC)) u_filt (
			.i_mclk(i_mclk),
			.i_rstn(i_rstn),
			.i_lvl(lw_s[gi]),
			.i_sel(i_sense_sel),
			.i_perm_en(perm_en),
			.i_smp(smp_ff),
			.i_clr(enter_sleep),
			.o_wake(lw_wake[gi])
		);
	end

	// ************************************************************
	// flags, set wins over a clearing read
	// ************************************************************
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			wake_st_ff <= '0;
			live_ff <= '0;
			spi_wake_ff <= 1'b0;
			can_wake_ff <= 1'b0;
			gs_ff <= 1'b0;
			rcause_ff <= 1'b1;
			batloss_ff <= 1'b1;
		end else begin
			if (awake) live_ff <= lw_s;
			wake_st_ff <= lw_wake | (i_rd_wake ? '0 : wake_st_ff);
			spi_wake_ff <= spi_hit || (spi_wake_ff && !i_rd_interrupt_source_reg_two);
			can_wake_ff <= (can_s && (awake || mode_ff == st_sleep)) || (can_wake_ff && !i_rd_wake_input_config_reg);
			gs_ff <= (tx_fall && canh_s[i_gs_sel]) || (gs_ff && !i_rd_gs);
			rcause_ff <= ((awake || mode_ff == st_nrq) && v1_low_s) || (rcause_ff && !i_rd_rsr);
			batloss_ff <= batloss_ff && !i_rd_supply_status_reg;
		end
	end

	// ************************************************************
	// supplies, watchdog run and interrupt
	// ************************************************************
	assign irq_vec = {can_wake_ff, |wake_st_ff, i_fault_src};

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			v1_en_ff <= 1'b1;
			v2_en_ff <= 1'b0;
			v3_ff <= 1'b0;
			wd_run_ff <= 1'b0;
			int_ff <= 1'b0;
		end else begin
			v1_en_ff <= (nxt_mode != st_sleep) && (nxt_mode != st_emerg);
			v2_en_ff <= (nxt_mode == st_normal);
			v3_ff <= ((nxt_mode == st_normal) || (nxt_mode == st_stby)) && i_v3_on;
			wd_run_ff <= (nxt_mode == st_normal) || (nxt_mode == st_stby);
			int_ff <= awake && |(irq_vec & i_irq_mask);
		end
	end

	assign o_mode = mode_ff;
	assign o_v1_en = v1_en_ff;
	assign o_v2_en = v2_en_ff;
	assign o_v3_en = v3_ff || cyc_on_ff;
	assign o_wd_run = wd_run_ff;
	assign o_rst_n_out = 1'b0;
	assign o_rst_n_oe = rst_drive;
	assign o_int_n = !int_ff;
	assign o_live_state = live_ff;
	assign o_wake_status = wake_st_ff;
	assign o_spi_wake = spi_wake_ff;
	assign o_can_wake = can_wake_ff;
	assign o_gs_shift = gs_ff;
	assign o_rst_cause = rcause_ff;
	assign o_battery_loss_flag = batloss_ff;

	// ************************************************************
	// checks
	// ************************************************************
	a_cyc_only_sleep: assert property (cyc_on_ff |-> $past(mode_ff) == st_sleep)
		else $error("switched output pulsed outside sleep");
	a_cyc_fwu_excl: assert property (!(slp_cyc_ff && slp_fwu_ff))
		else $error("cyclic sense and timed wake both armed");
	a_cyc_wins_fwu: assert property (enter_sleep && i_cyc_en |=> slp_cyc_ff && !slp_fwu_ff)
		else $error("timed wake armed beside cyclic sense");
	a_sample_time: assert property (smp_ff |-> cyc_on_ff && on_cnt_ff == TW'(P_CYC_SMP_US))
		else $error("wake sample not at its set time");
	a_pulse_length: assert property ($fell(cyc_on_ff) && mode_ff == st_sleep |-> on_cnt_ff == TW'(P_CYC_ON_US))
		else $error("switched output pulse has wrong length");
	a_reset_length: assert property ($fell(rst_drive) && mode_ff == st_reset |-> rst_cnt_ff == TW'(P_RST_US))
		else $error("reset pin released early");
	a_paired_write: assert property ($past(awake) && (mode_ff == st_emerg || ($changed(mode_ff) && awake))
		|-> $past(pair_hit))
		else $error("mode changed without paired write");
	a_sleep_clean: assert property ($past(awake) && mode_ff == st_sleep && !P_V1LOW_SLEEP |-> $past(!pend))
		else $error("sleep entered with pending wake flag");
	a_spi_wake: assert property (spi_hit |=> mode_ff == st_reset && spi_wake_ff)
		else $error("chip select wake missed");
	a_gs_flag: assert property (tx_fall && canh_s[i_gs_sel] |=> gs_ff)
		else $error("ground shift not flagged");
	a_int_cause: assert property (!o_int_n |-> $past(awake) && $past(|(irq_vec & i_irq_mask)))
		else $error("interrupt without enabled source");
	a_nrq_timeout: assert property (mode_ff == st_nrq && nrq_cnt_ff == TW'(P_NRQ_TO_US) && !i_wdt_wr
		&& !pair_hit && rst_pin_s && !v1_low_s |=> mode_ff == st_sleep)
		else $error("normal request timeout missed");
endmodule

// >>> sbc_host_model.sv
// Purpose: host side of the shared reset wire
// Assumes: wire has a pull-up, either party pulls low
// Notes: no keeper, released wire reads high
`timescale 1ns/1ps
module sbc_host_model (
	// device side
	input wire logic i_dev_oe,
	input wire logic i_dev_out,
	// host side
	input wire logic i_host_low,
	output logic o_rst_wire
);
	// ****
	// resolved level
	// ****
	assign o_rst_wire = ((i_dev_oe & ~i_dev_out) | i_host_low) ? 1'h0 : 1'h1;
endmodule

// >>> tb.sv
// Purpose: mode and wake-up sequencing bench
// Assumes: shortened timebase, one tick is two cycles
// Notes: inputs change just after the rising edge
`timescale 1ns/1ps
`include "sbc_consts.svh"
module tb;
	import sbc_pkg::*;
	// ****
	// stimulus and dut
	// ****
	logic i_mclk = 0, i_rstn = 0, i_mcr_wr = 0, i_mode_confirm_reg_wr = 0, i_wdt_wr = 0, i_wd_fail = 0;
	logic [2:0] i_mcr_code = 0, i_mode_confirm_reg_code = 0, i_cyc_sel = 0, i_local_wake = 0;
	logic i_cyc_en = 0, i_fwu_en = 0, i_wi2v3 = 0, i_v3_on = 0, i_cs_n = 1, i_txd = 1;
	logic i_can_wake = 0, i_v1_low = 0, i_v1_off = 0, host_low = 0, rst_wire;
	logic i_rd_wake = 0, i_rd_interrupt_source_reg_two = 0, i_rd_gs = 0, i_rd_wake_input_config_reg = 0, i_rd_rsr = 0, i_rd_supply_status_reg = 0;
	sbc_sense_t i_sense_sel = 0;
	logic [1:0] i_gs_sel = 0;
	logic [7:0] i_irq_mask = 0;
	logic [5:0] i_fault_src = 0;
	logic [3:0] i_canh_below = 0;
	logic [2:0] o_live_state, o_wake_status;
	logic o_rst_n_out, o_rst_n_oe, o_int_n, o_v1_en, o_v2_en, o_v3_en, o_wd_run;
	logic o_spi_wake, o_can_wake, o_gs_shift, o_rst_cause, o_battery_loss_flag;
	sbc_mode_t o_mode;
	int num_errors = 0, compares = 0, n;
	always #25 i_mclk = ~i_mclk;
	sbc_mode_ctrl #(.P_TICK_CYC(2), .P_FILT_CYC(4), .P_RST_US(10), .P_NRQ_TO_US(50), .P_V1LOW_US(20),
		.P_CYC_ON_US(4), .P_CYC_SMP_US(3), .P_CYC_BASE_US(40)) i_dut (.i_rst_n_pin(rst_wire), .*);
	sbc_host_model i_host (.i_dev_oe(o_rst_n_oe), .i_dev_out(o_rst_n_out), .i_host_low(host_low),
		.o_rst_wire(rst_wire));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge i_mclk);
		#1;
	endtask
	task automatic final_report();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// bounded: a hang is a mismatch and ends the run
	task automatic wait_mode(input sbc_mode_t m, input int lim);
		n = 0;
		while (o_mode !== m && n < lim) begin
			cyc(1);
			n++;
		end
		if (o_mode !== m) begin
			chk("mode wait", m, o_mode);
			final_report();
		end
	endtask
	task automatic wr_mode(input logic [2:0] a, input logic [2:0] b);
		@(posedge i_mclk);
		i_mcr_wr <= 1;
		i_mcr_code <= a;
		@(posedge i_mclk);
		i_mcr_wr <= 0;
		i_mode_confirm_reg_wr <= 1;
		i_mode_confirm_reg_code <= b;
		@(posedge i_mclk);
		i_mode_confirm_reg_wr <= 0;
		#1;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_reset();
		n = 0;
		while (o_rst_n_oe === 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk("reset length", 1, n >= 20 && n <= 24);
		wait_mode(st_nrq, 10);
		chk("rst cause", 1, o_rst_cause);
		chk("bat loss", 1, o_battery_loss_flag);
		$display("t_reset done");
	endtask
	task automatic t_nrq();
		wr_mode(`SBC_CODE_NORMAL, `SBC_CODE_NORMAL);
		chk("nrq ignores", st_nrq, o_mode);
		@(posedge i_mclk);
		i_wdt_wr <= 1;
		@(posedge i_mclk);
		i_wdt_wr <= 0;
		#1;
		chk("to normal", st_normal, o_mode);
		chk("v2 on", 1, o_v2_en);
		chk("wd run", 1, o_wd_run);
		$display("t_nrq done");
	endtask
	task automatic t_pair();
		wr_mode(`SBC_CODE_STBY, `SBC_CODE_NORMAL);
		chk("mismatch", st_normal, o_mode);
		wr_mode(`SBC_CODE_STBY, `SBC_CODE_STBY);
		chk("to stby", st_stby, o_mode);
		chk("v2 off", 0, o_v2_en);
		wr_mode(3'h3, 3'h3);
		chk("bad code", st_stby, o_mode);
		$display("t_pair done");
	endtask
	task automatic t_irq();
		i_irq_mask <= 8'h01;
		i_fault_src <= 6'h01;
		cyc(3);
		chk("int on", 0, o_int_n);
		i_irq_mask <= 8'h02;
		cyc(3);
		chk("int masked", 1, o_int_n);
		i_fault_src <= 6'h00;
		$display("t_irq done");
	endtask
	task automatic t_gs();
		i_canh_below <= 4'h4;
		for (int s = 1; s < 3; s++) begin
			i_gs_sel <= 2'(s);
			i_txd <= 1;
			cyc(4);
			i_txd <= 0;
			cyc(5);
			chk("gs shift", s == 2, o_gs_shift);
		end
		$display("t_gs done");
	endtask
	task automatic t_sleep();
		wr_mode(`SBC_CODE_SLEEP, `SBC_CODE_SLEEP);
		chk("sleep refused", st_stby, o_mode);
		i_rd_rsr <= 1;
		i_rd_supply_status_reg <= 1;
		i_rd_wake_input_config_reg <= 1;
		i_rd_gs <= 1;
		cyc(1);
		i_rd_rsr <= 0;
		i_rd_supply_status_reg <= 0;
		i_rd_wake_input_config_reg <= 0;
		i_rd_gs <= 0;
		cyc(1);
		chk("flags clear", 0, {o_rst_cause, o_battery_loss_flag, o_gs_shift, o_can_wake});
		wr_mode(`SBC_CODE_SLEEP, `SBC_CODE_SLEEP);
		chk("to sleep", st_sleep, o_mode);
		chk("supplies", 8'h01, {o_v1_en, o_v2_en, o_v3_en, o_rst_n_oe});
		$display("t_sleep done");
	endtask
	task automatic t_cs();
		i_v1_off <= 1;
		cyc(3);
		i_cs_n <= 0;
		wait_mode(st_reset, 8);
		chk("spi wake", 1, o_spi_wake);
		i_cs_n <= 1;
		i_v1_off <= 0;
		wait_mode(st_nrq, 40);
		$display("t_cs done");
	endtask
	task automatic t_ext();
		host_low <= 1;
		wait_mode(st_reset, 6);
		chk("no drive", 0, o_rst_n_oe);
		host_low <= 0;
		wait_mode(st_nrq, 10);
		$display("t_ext done");
	endtask
	// n holds the cycles waited for the switched output level
	task automatic cnt_v3(input logic lv);
		n = 0;
		while (o_v3_en !== lv && n < 200) begin
			cyc(1);
			n++;
		end
		if (o_v3_en !== lv) begin
			chk("v3 wait", lv, o_v3_en);
			final_report();
		end
	endtask
	task automatic t_wake();
		@(posedge i_mclk);
		i_wdt_wr <= 1;
		@(posedge i_mclk);
		i_wdt_wr <= 0;
		i_irq_mask <= 8'h40;
		i_sense_sel <= `SBC_SENSE_HIGH;
		i_wi2v3 <= 1;
		i_local_wake <= 3'h2;
		cyc(12);
		chk("live gated", 8'h02, {o_wake_status, o_live_state});
		i_v3_on <= 1;
		cyc(5);
		chk("wake int", 8'h12, {o_v3_en, o_int_n, o_wake_status});
		i_local_wake <= 3'h0;
		cyc(10);
		i_rd_wake <= 1;
		cyc(1);
		i_rd_wake <= 0;
		cyc(2);
		chk("wake clear", 8'h01, {o_wake_status, o_int_n});
		$display("t_wake done");
	endtask
	task automatic t_flt();
		i_wd_fail <= 1;
		cyc(1);
		i_wd_fail <= 0;
		chk("wd reset", 8'h03, {o_mode == st_reset, o_rst_n_oe});
		wait_mode(st_nrq, 40);
		i_v1_low <= 1;
		cyc(6);
		chk("v1 low", 8'h07, {o_mode == st_reset, o_rst_n_oe, o_rst_cause});
		i_v1_low <= 0;
		wait_mode(st_nrq, 40);
		$display("t_flt done");
	endtask
	task automatic t_cyc();
		@(posedge i_mclk);
		i_wdt_wr <= 1;
		i_rd_rsr <= 1;
		i_rd_interrupt_source_reg_two <= 1;
		@(posedge i_mclk);
		i_wdt_wr <= 0;
		i_rd_rsr <= 0;
		i_rd_interrupt_source_reg_two <= 0;
		i_cyc_en <= 1;
		i_fwu_en <= 1;
		i_cyc_sel <= 3'h1;
		wr_mode(`SBC_CODE_SLEEP, `SBC_CODE_SLEEP);
		chk("cyc sleep", st_sleep, o_mode);
		cnt_v3(1);
		chk("cyc period", 1, n >= 156 && n <= 164);
		cnt_v3(0);
		chk("cyc on", 1, n >= 7 && n <= 9);
		chk("no timed wake", st_sleep, o_mode);
		cnt_v3(1);
		cnt_v3(0);
		i_local_wake <= 3'h1;
		cnt_v3(1);
		cnt_v3(0);
		chk("one high", st_sleep, o_mode);
		wait_mode(st_reset, 200);
		chk("cyc flag", 3'h1, o_wake_status);
		wait_mode(st_nrq, 40);
		$display("t_cyc done");
	endtask
	task automatic t_to();
		wait_mode(st_sleep, 120);
		i_can_wake <= 1;
		wait_mode(st_reset, 6);
		chk("can flag", 1, o_can_wake);
		i_can_wake <= 0;
		wait_mode(st_nrq, 40);
		wr_mode(`SBC_CODE_EMERG, `SBC_CODE_EMERG);
		chk("emergency", 8'h09, {o_mode == st_emerg, o_v1_en, o_v3_en, o_rst_n_oe});
		$display("t_to done");
	endtask
	initial begin
		repeat (6) @(posedge i_mclk);
		i_rstn <= 1;
		cyc(1);
		t_reset();
		t_nrq();
		t_pair();
		t_irq();
		t_gs();
		t_sleep();
		t_cs();
		t_ext();
		t_wake();
		t_flt();
		t_cyc();
		t_to();
		final_report();
	end
endmodule
